/* hdl/hvgpio_defines.svh */
// Behaviour
// RL1: Clear direction and pull-up: high-Z or pulled-down input.
// RL2: Pull-up only gives pulled-up input; both reserved.
// RL3: Direction set, a pull clear: push/pull output.
// RL4: Direction and both pulls set: open-drain output.
// RL5: Strength bit picks low or high pull current.
// RL6: Receiver always active; port read returns pin.
// RL7: Threshold bit picks low or high receive threshold.
// RL8: Heavy-sink pins receive at high threshold in input.
// RL9: Threshold bit picks direct or divided ADC routing.
// RL10: LED enable with port bit high drives LED source.
// RL11: LED current code spans zero to maximum uniformly.
// RL12: Software checks driven-low pin and releases it.
// RL13: Software checks heavy-sink pull-down and disables it.
// RL14: Software prefers push/pull for inductive loads.
// RL15: Sensed level passes two flops before use.
`ifndef HVGPIO_DEFINES_SVH
`define HVGPIO_DEFINES_SVH
`define HVGPIO_GEN_PINS 15
`define HVGPIO_SINK_PINS 8
`define HVGPIO_LED_CODE_W 4
`define HVGPIO_LED_CODE_MAX 4'hF
`define HVGPIO_ADC_DIV 8
`endif

/* hdl/hvgpio_pkg.sv */
package hvgpio_pkg;
  typedef enum logic [1:0] {
    HVGPIO_HIZ_IN = 2'h0,
    HVGPIO_PULL_IN = 2'h1,
    HVGPIO_PUSH_PULL = 2'h3,
    HVGPIO_OPEN_DRAIN = 2'h2
  } hvgpio_func_t;
  typedef struct packed {
    logic pin_direction;
    logic pullup_enable;
    logic pulldown_enable;
    logic pull_strength;
    logic threshold_select;
  } hvgpio_cfg_t;
  typedef struct packed {
    logic outEn;
    logic outLevel;
    logic pullUpOn;
    logic pullDownOn;
    logic pullHigh;
    logic thrHigh;
    logic adcDivided;
    logic reserved;
  } hvgpio_pad_t;
endpackage

/* hdl/hvgpio_pad_config.sv */
`timescale 1ns/1ps
`include "hvgpio_defines.svh"
module hvgpio_pad_config
  import hvgpio_pkg::*;
#(
  parameter int GenPins = `HVGPIO_GEN_PINS,
  parameter int SinkPins = `HVGPIO_SINK_PINS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire hvgpio_cfg_t [GenPins+SinkPins-1:0] pinCfg,
  input wire logic [GenPins+SinkPins-1:0] portOut,
  input wire logic [GenPins+SinkPins-1:0] padIn,
  input wire logic led_source_enable,
  input wire logic [`HVGPIO_LED_CODE_W-1:0] ledCode,
  output hvgpio_pad_t [GenPins+SinkPins-1:0] padCtl_q,
  output logic [GenPins+SinkPins-1:0] padOutEnN_q,
  output logic [GenPins+SinkPins-1:0] portIn_q,
  output logic ledSourceOn_q,
  output logic [`HVGPIO_LED_CODE_W-1:0] ledCode_q
);
  localparam int Pins = GenPins + SinkPins;
  // Pin 0 is the LED-capable general pin.
  logic [Pins-1:0] padSync1_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      padSync1_q <= '0;
      portIn_q <= '0;
    end else begin
      padSync1_q <= padIn; // RL15
      portIn_q <= padSync1_q; // RL6 RL15
    end
  end

  genvar i;
  generate
    for (i = 0; i < Pins; i++) begin : g_pin
      hvgpio_cfg_t c;
      hvgpio_func_t f;
      hvgpio_pad_t d;
      assign c = pinCfg[i];
      always_comb begin
        if (!c.pin_direction) begin
          f = (c.pullup_enable || c.pulldown_enable) ? HVGPIO_PULL_IN : HVGPIO_HIZ_IN; // RL1 RL2
        end else if (c.pullup_enable && c.pulldown_enable) begin
          f = HVGPIO_OPEN_DRAIN; // RL4
        end else begin
          f = HVGPIO_PUSH_PULL; // RL3
        end
        d = '0;
        d.reserved = !c.pin_direction && c.pullup_enable && c.pulldown_enable; // RL2
        // The reserved input case enables no pull so both pulls never fight.
        d.pullUpOn = (f == HVGPIO_PULL_IN) && c.pullup_enable && !d.reserved; // RL2
        d.pullDownOn = (f == HVGPIO_PULL_IN) && c.pulldown_enable && !d.reserved; // RL1
        d.pullHigh = c.pull_strength; // RL5
        d.outEn = (f == HVGPIO_PUSH_PULL) || ((f == HVGPIO_OPEN_DRAIN) && !portOut[i]); // RL3 RL4
        d.outLevel = (f == HVGPIO_PUSH_PULL) && portOut[i]; // RL3 RL4
        if (i >= GenPins) begin
          d.thrHigh = !c.pin_direction || c.threshold_select; // RL8
        end else begin
          d.thrHigh = c.threshold_select; // RL7
        end
        d.adcDivided = c.threshold_select; // RL9
      end
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          padCtl_q[i] <= '0;
          padOutEnN_q[i] <= 1'h1;
        end else begin
          padCtl_q[i] <= d;
          padOutEnN_q[i] <= !d.outEn;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ledSourceOn_q <= 1'h0;
      ledCode_q <= '0;
    end else begin
      ledSourceOn_q <= led_source_enable && portOut[0]; // RL10
      ledCode_q <= ledCode; // RL11
    end
  end
endmodule

/* bench/hvgpio_loads.sv */
`timescale 1ns/1ps
module hvgpio_loads import hvgpio_pkg::*; (input wire hvgpio_pad_t [22:0] padCtl_q,
  input wire logic [22:0] padOutEnN_q, ext, output logic [22:0] padIn);
  // A released pin falls back to its pull, and only then to the outside source.
  always_comb for (int i = 0; i < 23; i++) padIn[i] = padOutEnN_q[i] ?
    padCtl_q[i][5] | ext[i] & !padCtl_q[i][4] : padCtl_q[i][6];
endmodule

/* bench/hvgpio_pad_config_sva.sv */
`timescale 1ns/1ps
module hvgpio_pad_config_sva import hvgpio_pkg::*;
#(parameter int GenPins = 15, SinkPins = 8, N = GenPins + SinkPins) (
  input wire logic sys_clk, rst, led_source_enable, ledSourceOn_q,
  input wire logic [3:0] ledCode, ledCode_q,
  input wire logic [N-1:0] portOut, padOutEnN_q,
  input wire hvgpio_cfg_t [N-1:0] pinCfg,
  input wire hvgpio_pad_t [N-1:0] padCtl_q);
  logic u_q, o;
  hvgpio_cfg_t c;
  wire hvgpio_pad_t p = padCtl_q[1];
  // Outputs answer one edge late, so the watched inputs are held back one edge.
  always_ff @(posedge sys_clk) {u_q, o, c} <= {!rst, portOut[1], pinCfg[1]};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst || !u_q);
  a_push_pull: assert property (c[4] & ~&c[3:2] |-> !padOutEnN_q[1] & p[6] == o)
    else $error("drive");
  a_open_drain: assert property (&c[4:2] |-> padOutEnN_q[1] == o && !p[6])
    else $error("drain");
  a_in_float: assert property (!c[4] & !c[3] |-> padOutEnN_q[1] && p[5:4] == {1'b0, c[2]})
    else $error("input");
  a_pull_up: assert property (c[4:2] == 3'h2 |-> p[5] && p[3] == c[1])
    else $error("pullup");
  a_rsv_combo: assert property (!c[4] |-> p[0] == &c[3:2])
    else $error("reserved");
  a_sink_thr: assert property (!$past(pinCfg[15][4]) |-> padCtl_q[15][2])
    else $error("sink");
  a_adc_route: assert property (p[1] == c[0] && p[2] == c[0])
    else $error("level");
  a_led_out: assert property ({ledSourceOn_q, ledCode_q} == $past({led_source_enable & portOut[0], ledCode}))
    else $error("led");
  c_open: cover property (&c[4:2] && !o);
  c_rsv: cover property (p[0]);
  c_led: cover property (ledSourceOn_q);
endmodule
bind hvgpio_pad_config hvgpio_pad_config_sva #(.GenPins(GenPins), .SinkPins(SinkPins)) i_sva (.*);

/* bench/hvgpio_pad_config_tb_top.sv */
`timescale 1ns/1ps
module hvgpio_pad_config_tb_top import hvgpio_pkg::*; ();
  logic sys_clk = 0, rst = 1, led_source_enable, ledSourceOn_q;
  logic [3:0] ledCode, ledCode_q;
  logic [22:0] portOut, padIn, ext, padOutEnN_q, portIn_q;
  hvgpio_cfg_t [22:0] pinCfg;
  hvgpio_pad_t [22:0] padCtl_q;
  int n_fail, n_tests;
  hvgpio_pad_config i_dut (.*);
  hvgpio_loads i_load (.*);
  always #20 sys_clk = ~sys_clk;
  task chk(logic [22:0] g, e);
    n_tests++;
    if (g !== e) $display("Error %0t got %h exp %h", $time, g, e);
    n_fail += (g !== e);
  endtask
  task final_report;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {pinCfg, portOut, ext, led_source_enable, ledCode} = '0;
    repeat (3) @(posedge sys_clk);
    #1 rst = 0;
    for (int k = 0; k < 128; k++) begin
      {pinCfg, portOut, ext, led_source_enable, ledCode} = {{23{k[4:0]}}, {23{k[5]}}, {23{k[6]}}, k[4:0]};
      repeat (3) @(posedge sys_clk);
      #1;
      chk(portIn_q, padIn);
      chk(padOutEnN_q, {23{!k[4] | &k[3:2] & k[5]}});
      chk({ledSourceOn_q, ledCode_q}, {k[4] & k[5], k[3:0]});
    end
    // Software guard: pins that read back low while driven or pulled low are released.
    {pinCfg, portOut, ext} = '0;
    pinCfg[2] = 5'h10;
    pinCfg[16] = 5'h04;
    pinCfg[17] = 5'h10;
    portOut[17] = 1'b1;
    ext = 23'h010004;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(padOutEnN_q, 23'h7DFFFB);
    chk(portIn_q, 23'h020000);
    pinCfg[2] = 5'h00;
    pinCfg[16] = 5'h00;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(portIn_q, 23'h030004);
    final_report();
  end
endmodule
